/* include/uvfr_consts.svh */
// Constants of the under-voltage fault response sequencer
`ifndef UVFR_CONSTS_SVH
`define UVFR_CONSTS_SVH

// ----------------------------------------------------------------
// Response byte layout and reset value
// ----------------------------------------------------------------
`define UVFR_CFG_W         8
`define UVFR_CFG_RESET     8'h00
`define UVFR_RESP_IGNORE   2'h0
`define UVFR_RESP_CONTINUE 2'h1
`define UVFR_RESP_SHUTDOWN 2'h2
`define UVFR_RESP_HOLD     2'h3
`define UVFR_RETRY_NONE    3'h0
`define UVFR_RETRY_FOREVER 3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define UVFR_UNIT_W        16
`define UVFR_UNITS_W       8
`define UVFR_UNITS_ONE     8'h01
`define UVFR_CNT_W         3
`define UVFR_CNT_ZERO      3'h0
`define UVFR_CNT_ONE       3'h1

`endif

/* include/uvfr_pkg.sv */
// Types of the under-voltage fault response sequencer
package uvfr_pkg;

  // ----------------------------------------------------------------
  // Response byte fields
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] delay;
  } uvfr_cfg_type;

  // ----------------------------------------------------------------
  // Sequencer states, Gray coded along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    UVFR_ST_RUN   = 3'h0,
    UVFR_ST_CONT  = 3'h1,
    UVFR_ST_WAIT  = 3'h3,
    UVFR_ST_TRY   = 3'h2,
    UVFR_ST_LATCH = 3'h6,
    UVFR_ST_HOLD  = 3'h7,
    UVFR_ST_OFF   = 3'h4
  } uvfr_state_type;

  // ----------------------------------------------------------------
  // Status seen by the monitoring side
  // ----------------------------------------------------------------
  typedef struct packed {
    logic           fault_latched;
    logic [2:0]     attempts;
    uvfr_state_type state;
  } uvfr_status_type;

endpackage : uvfr_pkg

/* hdl/uvfr_unit_timer.sv */
// Delay timer counting a number of time units of programmable length
`timescale 1ns/100ps
`default_nettype none
`include "uvfr_consts.svh"

module uvfr_unit_timer (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // Control
  input  wire logic                      start,
  input  wire logic [`UVFR_UNIT_W-1:0]   unit_cycles,
  input  wire logic [`UVFR_UNITS_W-1:0]  units,
  // Expiry
  output logic                           done
);

  logic [`UVFR_UNIT_W-1:0]  pre_q;
  logic [`UVFR_UNITS_W-1:0] left_q;
  logic                     run_q;
  logic [`UVFR_UNIT_W-1:0]  unit_last;

  // Zero unit length is treated as one cycle
  assign unit_last = (unit_cycles == '0) ? '0 : unit_cycles - `UVFR_UNIT_W'(1);

  // ----------------------------------------------------------------
  // Prescaler and unit counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q  <= '0;
      left_q <= '0;
      run_q  <= 1'b0;
    end else begin
      if (start) begin
        pre_q  <= unit_last;
        left_q <= units;
        run_q  <= 1'b1;
      end else if (run_q) begin
        if (pre_q == '0) begin
          pre_q <= unit_last;
          if (left_q == `UVFR_UNITS_ONE) begin
            run_q  <= 1'b0;
          end else begin
            left_q <= left_q - `UVFR_UNITS_ONE;
          end
        end else begin
          pre_q <= pre_q - `UVFR_UNIT_W'(1);
        end
      end
    end
  end

  // Expiry shows in the last cycle, so a restart lands exactly one delay after start
  assign done = run_q && (pre_q == '0) && (left_q == `UVFR_UNITS_ONE);

endmodule : uvfr_unit_timer
`default_nettype wire

/* hdl/uvfr_top.sv */
// Under-voltage fault response sequencer
//
// Operation
// (RULE1) Response code 00 keeps the output regulating with no interruption on a fault.
// (RULE2) Code 01 keeps operating for the delay and, if the fault remains, acts on the retry field.
// (RULE3) Code 10 disables the output at once and then follows the retry field.
// (RULE4) Code 11 holds the output off while the fault is present and resumes when it goes.
// (RULE5) A latched fault clears by its status bit clear, a clear-faults command, reset, or off-then-on.
// (RULE6) Retry field 000 makes no restart and keeps the output off until the fault is cleared.
// (RULE7) Retry field 1 to 6 tries that many restarts, then stays off until the fault is cleared.
// (RULE8) Restart attempts are spaced start to start by the delay count times the time unit.
// (RULE9) Retry field 111 retries without limit until commanded off or another fault shuts down.
// (RULE10) The delay field gives two to the power of its value in time units, 1 to 128.
// (RULE11) The time unit length comes from the separate time-unit register for both delays.
// (RULE12) The attempt counter resets when a restart succeeds or the fault is cleared.
`timescale 1ns/100ps
`default_nettype none
`include "uvfr_consts.svh"

module uvfr_top (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Response byte access from the command decoder
  input  wire logic                        cfg_wr,
  input  wire logic [`UVFR_CFG_W-1:0]      cfg_wdata,
  output logic      [`UVFR_CFG_W-1:0]      cfg_rdata,
  // Time unit from the time-unit register, in clock cycles
  input  wire logic [`UVFR_UNIT_W-1:0]     time_unit_cycles,
  // Fault and control pins
  input  wire logic                        uv_fault_pin,
  input  wire logic                        ctrl_pin,
  // Same-domain commands and events
  input  wire logic                        operation_on,
  input  wire logic                        clear_faults,
  input  wire logic                        status_bit_clear,
  input  wire logic                        other_fault,
  // Output control and status
  output logic                             output_enable,
  output logic                             restart_pulse,
  output uvfr_pkg::uvfr_status_type        status
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [`UVFR_CFG_W-1:0]      cfg_q;
  uvfr_pkg::uvfr_cfg_type      cfg;
  logic [2:0]                  uv_ff_q;
  logic [2:0]                  ctl_ff_q;
  logic                        uv_q;
  logic                        ctl_q;
  logic                        on_cmd;
  logic                        on_prev_q;
  logic                        on_rise;
  logic                        clear_evt;
  uvfr_pkg::uvfr_state_type    state_q;
  uvfr_pkg::uvfr_state_type    state_d;
  logic [`UVFR_CNT_W-1:0]      cnt_q;
  logic [`UVFR_CNT_W-1:0]      cnt_d;
  logic                        tmr_start;
  logic                        tmr_done;
  logic                        pulse_d;
  logic                        pulse_q;
  logic                        latched_q;
  logic                        latch_set;
  logic                        out_q;
  logic [`UVFR_UNITS_W-1:0]    units;

  assign cfg = uvfr_pkg::uvfr_cfg_type'(cfg_q);

  // ----------------------------------------------------------------
  // Response byte
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= `UVFR_CFG_RESET;
    end else if (cfg_wr) begin
      cfg_q <= cfg_wdata;
    end
  end

  assign cfg_rdata = cfg_q;

  // ----------------------------------------------------------------
  // Pin synchronisers, change taken when stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      uv_ff_q  <= 3'h0;
      ctl_ff_q <= 3'h0;
      uv_q     <= 1'b0;
      ctl_q    <= 1'b0;
    end else begin
      uv_ff_q  <= {uv_ff_q[1:0], uv_fault_pin};
      ctl_ff_q <= {ctl_ff_q[1:0], ctrl_pin};
      if (uv_ff_q[1] == uv_ff_q[2]) begin
        uv_q <= uv_ff_q[2];
      end
      if (ctl_ff_q[1] == ctl_ff_q[2]) begin
        ctl_q <= ctl_ff_q[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // On command and clear events
  // ----------------------------------------------------------------
  assign on_cmd = ctl_q & operation_on;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      on_prev_q <= 1'b0;
    end else begin
      on_prev_q <= on_cmd;
    end
  end

  assign on_rise   = on_cmd & ~on_prev_q;
  assign clear_evt = status_bit_clear | clear_faults | on_rise; // [RULE5]

  // ----------------------------------------------------------------
  // Delay timer
  // ----------------------------------------------------------------
  assign units = `UVFR_UNITS_ONE << cfg.delay; // [RULE10]

  uvfr_unit_timer u_timer (
    .clk         (clk),
    .rst_n       (rst_n),
    .start       (tmr_start),
    .unit_cycles (time_unit_cycles), // [RULE11]
    .units       (units),
    .done        (tmr_done)
  );

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    tmr_start = 1'b0;
    pulse_d   = 1'b0;
    latch_set = 1'b0;
    if (!on_cmd) begin
      state_d = uvfr_pkg::UVFR_ST_OFF; // [RULE9]
    end else if (other_fault) begin
      state_d = uvfr_pkg::UVFR_ST_LATCH; // [RULE9]
    end else begin
      unique case (state_q)
        uvfr_pkg::UVFR_ST_OFF: begin
          if (on_rise) begin
            state_d = uvfr_pkg::UVFR_ST_RUN;
            cnt_d   = `UVFR_CNT_ZERO; // [RULE12]
          end
        end
        uvfr_pkg::UVFR_ST_RUN: begin
          if (uv_q) begin
            latch_set = 1'b1;
            unique case (cfg.resp)
              `UVFR_RESP_IGNORE: begin
                state_d = uvfr_pkg::UVFR_ST_RUN; // [RULE1]
              end
              `UVFR_RESP_CONTINUE: begin
                state_d   = uvfr_pkg::UVFR_ST_CONT; // [RULE2]
                tmr_start = 1'b1;
              end
              `UVFR_RESP_SHUTDOWN: begin
                tmr_start = cfg.retry != `UVFR_RETRY_NONE;
                state_d   = tmr_start ? uvfr_pkg::UVFR_ST_WAIT
                                      : uvfr_pkg::UVFR_ST_LATCH; // [RULE3] [RULE6]
              end
              `UVFR_RESP_HOLD: begin
                state_d = uvfr_pkg::UVFR_ST_HOLD; // [RULE4]
              end
            endcase
          end
        end
        uvfr_pkg::UVFR_ST_CONT: begin
          if (tmr_done) begin
            if (!uv_q) begin
              state_d = uvfr_pkg::UVFR_ST_RUN;
            end else begin
              tmr_start = cfg.retry != `UVFR_RETRY_NONE;
              state_d   = tmr_start ? uvfr_pkg::UVFR_ST_WAIT
                                    : uvfr_pkg::UVFR_ST_LATCH; // [RULE2] [RULE6]
            end
          end
        end
        uvfr_pkg::UVFR_ST_WAIT: begin
          if (clear_evt) begin
            state_d = uvfr_pkg::UVFR_ST_RUN;
            cnt_d   = `UVFR_CNT_ZERO; // [RULE12]
          end else if (tmr_done) begin
            state_d   = uvfr_pkg::UVFR_ST_TRY;
            tmr_start = 1'b1; // [RULE8]
            pulse_d   = 1'b1;
            cnt_d     = cnt_q + `UVFR_CNT_ONE;
          end
        end
        uvfr_pkg::UVFR_ST_TRY: begin
          if (clear_evt) begin
            state_d = uvfr_pkg::UVFR_ST_RUN;
            cnt_d   = `UVFR_CNT_ZERO; // [RULE12]
          end else if (tmr_done) begin
            if (!uv_q) begin
              state_d = uvfr_pkg::UVFR_ST_RUN;
              cnt_d   = `UVFR_CNT_ZERO; // [RULE12]
            end else if (cfg.retry != `UVFR_RETRY_FOREVER && cnt_q >= cfg.retry) begin
              state_d = uvfr_pkg::UVFR_ST_LATCH; // [RULE7]
            end else begin
              tmr_start = 1'b1; // [RULE8] [RULE9]
              pulse_d   = 1'b1;
              if (cfg.retry != `UVFR_RETRY_FOREVER) begin
                cnt_d = cnt_q + `UVFR_CNT_ONE; // [RULE7]
              end
            end
          end
        end
        uvfr_pkg::UVFR_ST_LATCH: begin
          if (clear_evt) begin
            state_d = uvfr_pkg::UVFR_ST_RUN; // [RULE5] [RULE6] [RULE7]
            cnt_d   = `UVFR_CNT_ZERO; // [RULE12]
          end
        end
        uvfr_pkg::UVFR_ST_HOLD: begin
          if (!uv_q) begin
            state_d = uvfr_pkg::UVFR_ST_RUN; // [RULE4]
          end
        end
        default: begin
          state_d = uvfr_pkg::UVFR_ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state, attempt counter and output control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= uvfr_pkg::UVFR_ST_OFF;
      cnt_q   <= `UVFR_CNT_ZERO;
      pulse_q <= 1'b0;
      out_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      pulse_q <= pulse_d;
      out_q   <= (state_d == uvfr_pkg::UVFR_ST_RUN)
              || (state_d == uvfr_pkg::UVFR_ST_CONT)
              || (state_d == uvfr_pkg::UVFR_ST_TRY); // [RULE1] [RULE2] [RULE3] [RULE4]
    end
  end

  // ----------------------------------------------------------------
  // Latched fault flag, set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_q <= 1'b0; // [RULE5]
    end else if (latch_set) begin
      latched_q <= 1'b1;
    end else if (clear_evt) begin
      latched_q <= 1'b0; // [RULE5]
    end
  end

  assign output_enable        = out_q;
  assign restart_pulse        = pulse_q;
  assign status.fault_latched = latched_q;
  assign status.attempts      = cnt_q;
  assign status.state         = state_q;

endmodule : uvfr_top
`default_nettype wire

/* verification/uvfr_chk.sv */
// Assertion checker for the under-voltage fault response sequencer
`timescale 1ns/100ps
`default_nettype none
`include "uvfr_consts.svh"

module uvfr_chk (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       rst_n,
  // Configuration and commands
  input wire logic                       cfg_wr,
  input wire logic [`UVFR_CFG_W-1:0]     cfg_rdata,
  input wire logic [`UVFR_UNIT_W-1:0]    time_unit_cycles,
  input wire logic                       ctrl_pin,
  input wire logic                       operation_on,
  input wire logic                       clear_faults,
  input wire logic                       status_bit_clear,
  input wire logic                       other_fault,
  // Outputs
  input wire logic                       output_enable,
  input wire logic                       restart_pulse,
  input wire uvfr_pkg::uvfr_status_type  status
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [2:0]  ctrl_cnt_q;
  logic [23:0] gap_q;
  logic [23:0] exp_gap;
  logic        calm;
  logic        try_seen_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) try_seen_q <= 1'b0;
    else if (restart_pulse) try_seen_q <= 1'b1;
    else if (status.state != uvfr_pkg::UVFR_ST_TRY) try_seen_q <= 1'b0;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ctrl_cnt_q <= 3'h0;
    else if (!ctrl_pin) ctrl_cnt_q <= 3'h0;
    else if (ctrl_cnt_q != 3'h7) ctrl_cnt_q <= ctrl_cnt_q + 3'h1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) gap_q <= 24'h0;
    else if (restart_pulse) gap_q <= 24'h1;
    else gap_q <= gap_q + 24'h1;
  end
  assign exp_gap = {8'h0, (time_unit_cycles == 16'h0) ? 16'h1 : time_unit_cycles}
                   << cfg_rdata[2:0];
  assign calm = (ctrl_cnt_q == 3'h7) && operation_on && !other_fault && !cfg_wr;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ignore_keeps_on: assert property (
    $past(status.state) == uvfr_pkg::UVFR_ST_RUN && status.state == uvfr_pkg::UVFR_ST_RUN
    && cfg_rdata[7:6] == 2'h0 && calm |=> status.state == uvfr_pkg::UVFR_ST_RUN && output_enable)
    else $error("output left regulation under ignore response");
  a_continue_on_fault: assert property (
    $rose(status.fault_latched) && cfg_rdata[7:6] == 2'h1 && calm
    |-> status.state == uvfr_pkg::UVFR_ST_CONT && output_enable)
    else $error("continue response did not keep output on");
  a_disable_at_once: assert property (
    $rose(status.fault_latched) && cfg_rdata[7:6] == 2'h2 |-> !output_enable)
    else $error("disable response left output on");
  a_hold_while_fault: assert property (
    $rose(status.fault_latched) && cfg_rdata[7:6] == 2'h3 && calm
    |-> status.state == uvfr_pkg::UVFR_ST_HOLD && !output_enable)
    else $error("hold response did not turn output off");
  a_latch_stays_off: assert property (
    status.state == uvfr_pkg::UVFR_ST_LATCH |-> !output_enable && !restart_pulse)
    else $error("latched state drives output");
  a_retry_count_limit: assert property (
    restart_pulse |-> output_enable && status.attempts != 3'h0
    && (cfg_rdata[5:3] == 3'h7 || status.attempts <= cfg_rdata[5:3]))
    else $error("restart beyond programmed count");
  a_restart_spacing: assert property (
    restart_pulse && try_seen_q |-> gap_q == exp_gap)
    else $error("restart spacing wrong");
  a_endless_retry: assert property (
    status.state == uvfr_pkg::UVFR_ST_TRY && cfg_rdata[5:3] == 3'h7 && calm
    |=> status.state != uvfr_pkg::UVFR_ST_LATCH)
    else $error("endless retry gave up");
  a_clear_resumes: assert property (
    (clear_faults || status_bit_clear) && status.state == uvfr_pkg::UVFR_ST_LATCH && calm
    |=> status.state == uvfr_pkg::UVFR_ST_RUN && status.attempts == 3'h0)
    else $error("clear did not resume operation");
endmodule : uvfr_chk

bind uvfr_top uvfr_chk i_chk (
  .clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rdata(cfg_rdata),
  .time_unit_cycles(time_unit_cycles), .ctrl_pin(ctrl_pin), .operation_on(operation_on),
  .clear_faults(clear_faults), .status_bit_clear(status_bit_clear),
  .other_fault(other_fault), .output_enable(output_enable),
  .restart_pulse(restart_pulse), .status(status)
);
`default_nettype wire

/* verification/uvfr_host.sv */
// Host model issuing response byte writes and clear commands
`timescale 1ns/100ps
`default_nettype none

module uvfr_host (
  // Clock
  input  wire logic        clk,
  // Request from the bench
  input  wire logic        go,
  input  wire logic [1:0]  kind,
  input  wire logic [7:0]  data,
  // Strobes towards the block
  output var  logic        cfg_wr,
  output var  logic [7:0]  cfg_wdata,
  output var  logic        clear_faults,
  output var  logic        status_bit_clear
);
  initial begin
    {cfg_wr, cfg_wdata, clear_faults, status_bit_clear} = 11'h0;
  end
  // One-cycle strobes; idle data bus toggles so stale bytes are never seen
  always @(posedge clk) begin
    cfg_wr           <= go && kind == 2'h0;
    clear_faults     <= go && kind == 2'h1;
    status_bit_clear <= go && kind == 2'h2;
    cfg_wdata        <= (go && kind == 2'h0) ? data : ~cfg_wdata;
  end
endmodule : uvfr_host
`default_nettype wire

/* verification/tb.sv */
// Testbench for the under-voltage fault response sequencer
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, uv = 1'b0, ctrl = 1'b1, op_on = 1'b1, oth = 1'b0;
  logic [1:0]  kind = 2'h0;
  logic [7:0]  data = 8'h0;
  logic [15:0] unit = 16'h2;
  logic        cfg_wr, clr, sbc, oe, rp;
  logic [7:0]  wdata, rdata;
  uvfr_pkg::uvfr_status_type st;
  int fail_count = 0, comparisons = 0, pulses = 0;

  uvfr_top i_dut (.clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_wdata(wdata),
    .cfg_rdata(rdata), .time_unit_cycles(unit), .uv_fault_pin(uv), .ctrl_pin(ctrl),
    .operation_on(op_on), .clear_faults(clr), .status_bit_clear(sbc), .other_fault(oth),
    .output_enable(oe), .restart_pulse(rp), .status(st));
  uvfr_host i_host (.clk(clk), .go(go), .kind(kind), .data(data), .cfg_wr(cfg_wr),
    .cfg_wdata(wdata), .clear_faults(clr), .status_bit_clear(sbc));

  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (rp === 1'b1) pulses++;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic host_cmd(input logic [1:0] k, input logic [7:0] d);
    @(posedge clk);
    go <= 1'b1; kind <= k; data <= d;
    @(posedge clk);
    go <= 1'b0;
    cyc(2);
  endtask : host_cmd
  task automatic set_uv(input logic v);
    @(posedge clk);
    uv <= v;
  endtask : set_uv
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got 0x%0h, expected 0x%0h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_st(input uvfr_pkg::uvfr_state_type e, input logic en);
    chk(8'(st.state), 8'(e));
    chk({7'h0, oe}, {7'h0, en});
  endtask : chk_st
  task automatic wr_cfg(input logic [7:0] v);
    host_cmd(2'h0, v);
    chk(rdata, v);
  endtask : wr_cfg
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  initial begin
    #100us;
    fail_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    cyc(10);
    chk_st(uvfr_pkg::UVFR_ST_RUN, 1'b1);
    chk(rdata, 8'h00);
    set_uv(1'b1);
    cyc(10);
    chk_st(uvfr_pkg::UVFR_ST_RUN, 1'b1);
    set_uv(1'b0);
    cyc(6);
    host_cmd(2'h1, 8'h0);
    chk({7'h0, st.fault_latched}, 8'h0);
    wr_cfg(8'h41);
    set_uv(1'b1);
    cyc(7);
    chk_st(uvfr_pkg::UVFR_ST_CONT, 1'b1);
    cyc(12);
    chk_st(uvfr_pkg::UVFR_ST_LATCH, 1'b0);
    set_uv(1'b0);
    cyc(6);
    host_cmd(2'h2, 8'h0);
    chk_st(uvfr_pkg::UVFR_ST_RUN, 1'b1);
    wr_cfg(8'h90);
    pulses = 0;
    set_uv(1'b1);
    cyc(30);
    chk_st(uvfr_pkg::UVFR_ST_LATCH, 1'b0);
    chk(8'(pulses), 8'h2);
    set_uv(1'b0);
    cyc(6);
    host_cmd(2'h1, 8'h0);
    chk({5'h0, st.attempts}, 8'h0);
    @(posedge clk);
    unit <= 16'h3;
    wr_cfg(8'hb8);
    pulses = 0;
    set_uv(1'b1);
    cyc(60);
    chk({7'h0, pulses >= 8}, 8'h1);
    set_uv(1'b0);
    cyc(15);
    chk_st(uvfr_pkg::UVFR_ST_RUN, 1'b1);
    host_cmd(2'h1, 8'h0);
    chk({7'h0, st.fault_latched}, 8'h0);
    wr_cfg(8'hc0);
    set_uv(1'b1);
    cyc(8);
    chk_st(uvfr_pkg::UVFR_ST_HOLD, 1'b0);
    set_uv(1'b0);
    cyc(8);
    chk_st(uvfr_pkg::UVFR_ST_RUN, 1'b1);
    wr_cfg(8'h80);
    set_uv(1'b1);
    cyc(8);
    set_uv(1'b0);
    op_on <= 1'b0;
    cyc(4);
    chk_st(uvfr_pkg::UVFR_ST_OFF, 1'b0);
    @(posedge clk);
    op_on <= 1'b1;
    cyc(4);
    chk_st(uvfr_pkg::UVFR_ST_RUN, 1'b1);
    chk({7'h0, st.fault_latched}, 8'h0);
    @(posedge clk);
    oth <= 1'b1;
    cyc(2);
    chk_st(uvfr_pkg::UVFR_ST_LATCH, 1'b0);
    @(posedge clk);
    oth <= 1'b0;
    cyc(2);
    chk_st(uvfr_pkg::UVFR_ST_LATCH, 1'b0);
    host_cmd(2'h2, 8'h0);
    chk_st(uvfr_pkg::UVFR_ST_RUN, 1'b1);
    @(posedge clk);
    ctrl <= 1'b0;
    cyc(8);
    chk_st(uvfr_pkg::UVFR_ST_OFF, 1'b0);
    @(posedge clk);
    ctrl <= 1'b1;
    cyc(8);
    chk_st(uvfr_pkg::UVFR_ST_RUN, 1'b1);
    test_done();
  end
endmodule : tb
`default_nettype wire
